/* File: core/esm_timing_ctrl.sv */
/*
 * Timing controller for a flow-through ECC DRAM system with refresh scrubbing and
 * correct-only-on-error mode, plus an APB register port.
 * Assumes synchronous processor inputs, an external DRAM controller and two ECC units.
 */
`timescale 1ns/1ps
module esm_timing_ctrl
	import esm_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Processor bus
	input  wire logic        cpu_address_strobe,
	input  wire logic        mem_select_n,
	input  wire logic        cpu_read,
	output logic             transfer_acknowledge_n,
	output logic             cpu_bus_fault_n,
	output logic             cpu_halt_n,
	// DRAM controller
	output logic             ras_request_n,
	output logic             addr_latch_en,
	output logic             refresh_mode,
	output logic             refresh_done_n,
	// Access correction unit
	input  wire logic        access_err_n,
	output logic             acc_dir,
	output logic             acc_oe_n,
	output logic             acc_latch_en,
	output logic             correct_mode_select,
	// Scrubbing correction unit
	output logic             scr_dir,
	output logic             scr_oe_n
);
	esm_state_type    state_d, state_q;
	logic [2:0]       cnt;
	logic             cnt_clr;
	logic             ref_pend_d, ref_pend_q;
	logic             served_d, served_q;
	logic             scrub_wr_d, scrub_wr_q;
	logic [1:0]       ctrl_d, ctrl_q;
	logic [15:0]      scrub_fix_d, scrub_fix_q;
	logic [15:0]      read_fix_d, read_fix_q;
	logic [15:0]      sweeps_d, sweeps_q;
	logic             tick, wrap, acc_pend, scrub_en, coe_mode;
	logic [LOC_W-1:0] location;
	logic             ras_n_d, alatch_d, rmode_d, rdone_n_d, ack_n_d, fault_n_d;
	logic             adir_d, aoe_n_d, ale_d, correct_mode_select_d, sdir_d, soe_n_d;
	logic             ras_n_q, alatch_q, rmode_q, rdone_n_q, ack_n_q, fault_n_q, halt_n_q;
	logic             adir_q, aoe_n_q, ale_q, correct_mode_select_q, sdir_q, soe_n_q;
	logic [31:0]      prdata_d, prdata_q;
	logic             pready_d, pready_q, pslverr_d, pslverr_q, apb_wr;

	assign scrub_en = ctrl_q[CTRL_SCRUB_BIT];
	assign coe_mode = ctrl_q[CTRL_COE_BIT];
	assign acc_pend = cpu_address_strobe && !mem_select_n && !served_q;

	esm_cycle_counter u_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (cnt_clr),
		.count   (cnt)
	);

	esm_sweep_timer u_sweep (
		.pclk          (pclk),
		.presetn       (presetn),
		.refresh_taken (state_q == ST_REFRESH && cnt == 3'h0),
		.refresh_tick  (tick),
		.sweep_wrap    (wrap),
		.location      (location)
	);

	// Sequencer
	always_comb begin
		state_d    = state_q;
		scrub_wr_d = scrub_wr_q;
		ref_pend_d = ref_pend_q;
		if (state_q == ST_REFRESH && cnt == 3'h0) begin
			ref_pend_d = 1'b0;
		end
		if (tick) begin
			ref_pend_d = 1'b1;
		end
		served_d = served_q;
		if (!cpu_address_strobe) begin
			served_d = 1'b0;
		end else if (!ack_n_d) begin
			served_d = 1'b1;
		end
		case (state_q)
			ST_IDLE: begin
				state_d = ST_RAS_DLY;
			end
			ST_RAS_DLY, ST_ACCESS_CHK: begin
				if (ref_pend_q) begin
					state_d    = ST_REFRESH;
					scrub_wr_d = 1'b0;
				end else if (acc_pend) begin
					state_d = cpu_read ? ST_READ : ST_WRITE;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (cnt == CNT_ACCESS_LAST) begin
					state_d = ST_ACCESS_CHK;
				end
			end
			ST_READ: begin
				if (cnt == CNT_ACCESS_LAST) begin
					state_d = access_err_n ? ST_ACCESS_CHK : ST_CORRECT;
				end
			end
			ST_CORRECT: begin
				if (cnt == CNT_CORRECT_LAST) begin
					state_d = ST_ACCESS_CHK;
				end
			end
			ST_REFRESH: begin
				if (scrub_en && cnt == CNT_DECIDE) begin
					scrub_wr_d = !access_err_n;
				end
				if (cnt == (scrub_en ? CNT_SCRUB_LAST : CNT_REFRESH_LAST)) begin
					state_d = ST_ACCESS_CHK;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		cnt_clr = (state_d != state_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_IDLE;
			ref_pend_q <= 1'b0;
			served_q   <= 1'b0;
			scrub_wr_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			ref_pend_q <= ref_pend_d;
			served_q   <= served_d;
			scrub_wr_q <= scrub_wr_d;
		end
	end

	// Control outputs
	always_comb begin
		ras_n_d   = 1'b1;
		alatch_d  = 1'b1;
		rmode_d   = 1'b0;
		rdone_n_d = 1'b1;
		ack_n_d   = 1'b1;
		adir_d    = 1'b1;
		aoe_n_d   = 1'b1;
		ale_d     = 1'b0;
		correct_mode_select_d    = !coe_mode;
		sdir_d    = 1'b1;
		soe_n_d   = 1'b1;
		case (state_q)
			ST_WRITE: begin
				adir_d  = 1'b0;
				aoe_n_d = 1'b0;
				ras_n_d = (cnt == 3'h0);
				ack_n_d = (cnt != CNT_ACK);
				correct_mode_select_d  = !coe_mode;
			end
			ST_READ: begin
				aoe_n_d  = (cnt == 3'h0);
				ras_n_d  = (cnt == 3'h0);
				ack_n_d  = (cnt != CNT_ACK);
				ale_d    = (cnt == CNT_ACCESS_LAST);
				alatch_d = access_err_n;
				correct_mode_select_d   = !coe_mode;
			end
			ST_CORRECT: begin
				adir_d   = 1'b0;
				aoe_n_d  = 1'b0;
				ras_n_d  = 1'b0;
				alatch_d = 1'b0;
				correct_mode_select_d   = 1'b1;
			end
			ST_REFRESH: begin
				rmode_d   = 1'b1;
				ras_n_d   = (cnt > CNT_REFRESH_LAST);
				aoe_n_d   = 1'b1;
				soe_n_d   = !scrub_en;
				sdir_d    = !(scrub_wr_q && cnt >= CNT_SCRUB_WR);
				rdone_n_d = (cnt != (scrub_en ? CNT_SCRUB_LAST : CNT_REFRESH_LAST));
			end
			default: begin
				ras_n_d = 1'b1;
			end
		endcase
		// Read-direction error reaches the processor only when correction is deferred
		fault_n_d = !(coe_mode && ((adir_q && !access_err_n && state_q == ST_READ)
			|| state_q == ST_CORRECT));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ras_n_q   <= 1'b1;
			alatch_q  <= 1'b1;
			rmode_q   <= 1'b0;
			rdone_n_q <= 1'b1;
			ack_n_q   <= 1'b1;
			fault_n_q <= 1'b1;
			halt_n_q  <= 1'b1;
			adir_q    <= 1'b1;
			aoe_n_q   <= 1'b1;
			ale_q     <= 1'b0;
			correct_mode_select_q    <= 1'b0;
			sdir_q    <= 1'b1;
			soe_n_q   <= 1'b1;
		end else begin
			ras_n_q   <= ras_n_d;
			alatch_q  <= alatch_d;
			rmode_q   <= rmode_d;
			rdone_n_q <= rdone_n_d;
			ack_n_q   <= ack_n_d;
			fault_n_q <= fault_n_d;
			halt_n_q  <= fault_n_d;
			adir_q    <= adir_d;
			aoe_n_q   <= aoe_n_d;
			ale_q     <= ale_d;
			correct_mode_select_q    <= correct_mode_select_d;
			sdir_q    <= sdir_d;
			soe_n_q   <= soe_n_d;
		end
	end

	// Register port and event counters
	always_comb begin
		apb_wr      = psel && penable && pready_q && pwrite;
		ctrl_d      = (apb_wr && paddr == ESM_CTRL_OFS) ? pwdata[1:0] : ctrl_q;
		scrub_fix_d = (state_q == ST_REFRESH && cnt == CNT_SCRUB_WR && scrub_wr_q)
			? 16'(scrub_fix_q + 16'h1) : scrub_fix_q;
		read_fix_d  = (state_q != ST_CORRECT && state_d == ST_CORRECT)
			? 16'(read_fix_q + 16'h1) : read_fix_q;
		sweeps_d    = wrap ? 16'(sweeps_q + 16'h1) : sweeps_q;
		pready_d    = psel && !penable;
		pslverr_d   = 1'b0;
		prdata_d    = 32'h0;
		if (psel && !penable) begin
			case (paddr)
				ESM_CTRL_OFS:  prdata_d = {30'h0, ctrl_q};
				ESM_STAT_OFS:  prdata_d = {7'h0, location, ref_pend_q, 1'b0, state_q};
				ESM_SCRUB_OFS: prdata_d = {sweeps_q, scrub_fix_q};
				ESM_FIX_OFS:   prdata_d = {16'h0, read_fix_q};
				default:       pslverr_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= CTRL_RESET;
			scrub_fix_q <= 16'h0;
			read_fix_q  <= 16'h0;
			sweeps_q    <= 16'h0;
			prdata_q    <= 32'h0;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			scrub_fix_q <= scrub_fix_d;
			read_fix_q  <= read_fix_d;
			sweeps_q    <= sweeps_d;
			prdata_q    <= prdata_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
		end
	end

	assign prdata                 = prdata_q;
	assign pready                 = pready_q;
	assign pslverr                = pslverr_q;
	assign transfer_acknowledge_n = ack_n_q;
	assign cpu_bus_fault_n        = fault_n_q;
	assign cpu_halt_n             = halt_n_q;
	assign ras_request_n          = ras_n_q;
	assign addr_latch_en          = alatch_q;
	assign refresh_mode           = rmode_q;
	assign refresh_done_n         = rdone_n_q;
	assign acc_dir                = adir_q;
	assign acc_oe_n               = aoe_n_q;
	assign acc_latch_en           = ale_q;
	assign correct_mode_select    = correct_mode_select_q;
	assign scr_dir                = sdir_q;
	assign scr_oe_n               = soe_n_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	scrub_decide_a: assert property (state_q == ST_REFRESH && cnt == CNT_DECIDE && scrub_en && !access_err_n
		|=> scrub_wr_q ##1 (!sdir_q)[*2]) else $error("scrub write not started");
	cpu_oe_off_a: assert property (state_q == ST_REFRESH |=> acc_oe_n) else $error("cpu side driven in refresh");
	refresh_len_a: assert property ($rose(state_q == ST_REFRESH) && scrub_en
		|-> (state_q == ST_REFRESH)[*6] ##1 state_q == ST_ACCESS_CHK) else $error("scrub refresh length wrong");
	read_modify_a: assert property (state_q == ST_READ && cnt == CNT_ACCESS_LAST && !access_err_n
		|=> state_q == ST_CORRECT) else $error("no modify-write after read error");
	write_nofault_a: assert property (state_q == ST_WRITE |=> cpu_bus_fault_n) else $error("fault in write");
	correct_mode_select_low_a: assert property (coe_mode && state_q == ST_WRITE |=> !correct_mode_select) else $error("correct_mode_select set");
	refresh_first_a: assert property ((state_q == ST_RAS_DLY || state_q == ST_ACCESS_CHK) && ref_pend_q
		|=> state_q == ST_REFRESH) else $error("refresh not first");
	refresh_wait_a: assert property (state_q == ST_REFRESH |=> transfer_acknowledge_n) else $error("ack in refresh");
	scrub_read_a: assert property (state_q == ST_REFRESH && cnt == 3'h0 && scrub_en
		|=> scr_dir && !scr_oe_n) else $error("scrub unit not reading");
	latch_hold_a: assert property (state_q == ST_CORRECT |=> !addr_latch_en) else $error("latch open in fix");
	reset_idle_a: assert property (state_q == ST_IDLE |-> ##1 state_q == ST_RAS_DLY) else $error("idle stuck");

	scrub_cov: cover property (state_q == ST_REFRESH && scrub_wr_q && cnt == CNT_SCRUB_LAST);
	modify_cov: cover property (state_q == ST_CORRECT && coe_mode);
	ref_access_cov: cover property (state_q == ST_REFRESH ##1 state_q == ST_ACCESS_CHK ##1 state_q == ST_READ);
endmodule

/* File: include/esm_pkg.sv */
/*
 * Constants, register map and state type for the scrubbing ECC memory timing controller.
 * Assumes a 25 MHz pclk and a 32-bit APB register port.
 */
package esm_pkg;
	localparam logic [7:0]  ESM_CTRL_OFS     = 8'h00;
	localparam logic [7:0]  ESM_STAT_OFS     = 8'h04;
	localparam logic [7:0]  ESM_SCRUB_OFS    = 8'h08;
	localparam logic [7:0]  ESM_FIX_OFS      = 8'h0c;
	localparam int          CTRL_SCRUB_BIT   = 0;
	localparam int          CTRL_COE_BIT     = 1;
	localparam logic [1:0]  CTRL_RESET       = 2'h1;
	localparam logic [2:0]  CNT_ACK          = 3'h2;
	localparam logic [2:0]  CNT_ACCESS_LAST  = 3'h3;
	localparam logic [2:0]  CNT_CORRECT_LAST = 3'h2;
	localparam logic [2:0]  CNT_REFRESH_LAST = 3'h2;
	localparam logic [2:0]  CNT_DECIDE       = 3'h3;
	localparam logic [2:0]  CNT_SCRUB_WR     = 3'h4;
	localparam logic [2:0]  CNT_SCRUB_LAST   = 3'h5;
	localparam longint      SWEEP_TIME_US    = 64'd16384000;
	localparam longint      CLK_MHZ          = 64'd25;
	localparam longint      SWEEP_LOCATIONS  = 64'd1048576;
	localparam logic [8:0]  REF_INTERVAL_CYC = 9'(SWEEP_TIME_US * CLK_MHZ / SWEEP_LOCATIONS);
	localparam int          LOC_W            = 20;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RAS_DLY, ST_ACCESS_CHK, ST_WRITE, ST_READ, ST_CORRECT, ST_REFRESH
	} esm_state_type;
endpackage

/* File: core/esm_cycle_counter.sv */
/*
 * Three-bit cycle counter with synchronous clear, numbering the counts of each cycle.
 * Assumes clear is raised on every state change.
 */
`timescale 1ns/1ps
module esm_cycle_counter
	import esm_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       clear,
	output logic [2:0]      count
);
	logic [2:0] count_d;
	logic [2:0] count_q;

	always_comb begin
		count_d = clear ? 3'h0 : 3'(count_q + 3'h1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 3'h0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
endmodule

/* File: core/esm_sweep_timer.sv */
/*
 * Refresh pacing timer and scrub location counter; one refresh per interval covers
 * every location once per sweep.
 * Assumes each tick is served by exactly one refresh.
 */
`timescale 1ns/1ps
module esm_sweep_timer
	import esm_pkg::*;
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Pacing
	input  wire logic             refresh_taken,
	output logic                  refresh_tick,
	output logic                  sweep_wrap,
	output logic [LOC_W-1:0]      location
);
	logic [8:0]       timer_d, timer_q;
	logic             tick_d, tick_q;
	logic [LOC_W-1:0] loc_d, loc_q;
	logic             wrap_d, wrap_q;

	always_comb begin
		tick_d  = (timer_q == 9'(REF_INTERVAL_CYC - 9'h1));
		timer_d = tick_d ? 9'h0 : 9'(timer_q + 9'h1);
		loc_d   = refresh_taken ? LOC_W'(loc_q + 1'b1) : loc_q;
		wrap_d  = refresh_taken && (loc_q == {LOC_W{1'b1}});
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_q <= 9'h0;
			tick_q  <= 1'b0;
			loc_q   <= '0;
			wrap_q  <= 1'b0;
		end else begin
			timer_q <= timer_d;
			tick_q  <= tick_d;
			loc_q   <= loc_d;
			wrap_q  <= wrap_d;
		end
	end

	assign refresh_tick = tick_q;
	assign sweep_wrap   = wrap_q;
	assign location     = loc_q;
endmodule

/* File: tb/esm_far_model.sv */
/*
 * Far-side model: error flag of the access correction unit, raised on demand.
 * Assumes the bench sets inject while a faulty word is on the memory bus.
 */
`timescale 1ns/1ps
module esm_far_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Bench control
	input  wire logic inject,
	input  wire logic any_dir,
	// Controller outputs seen
	input  wire logic refresh_mode,
	input  wire logic acc_dir,
	input  wire logic scr_dir,
	// Error flag
	output logic      access_err_n
);
	logic err_d;
	always_comb begin
		// Scrub unit reads in refresh, access unit both watches and flags
		err_d = !(inject && (any_dir || (refresh_mode ? scr_dir : acc_dir)));
	end
	// Flag moves only after a rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_err_n <= 1'b1;
		end else begin
			access_err_n <= err_d;
		end
	end
endmodule

/* File: tb/edac_scrub_memory_timing_ctrl_tb.sv */
/*
 * Self-checking bench of the scrubbing ECC timing controller.
 * Assumes esm_timing_ctrl and the far-side error flag model.
 */
`timescale 1ns/1ps
module edac_scrub_memory_timing_ctrl_tb;
	import esm_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, ack, flt, cms, lat, wdir, ale;
	logic        cpu_address_strobe = 0, mem_select_n = 1, cpu_read = 0;
	logic        transfer_acknowledge_n, cpu_bus_fault_n, cpu_halt_n, ras_request_n, addr_latch_en;
	logic        refresh_mode, refresh_done_n, access_err_n, acc_dir, acc_oe_n, acc_latch_en;
	logic        correct_mode_select, scr_dir, scr_oe_n, inject = 0, any_dir = 0;
	logic [40:0] rows [5];
	int          err_count = 0, n_checks = 0, ref_cyc = 0, ref_len = 0, scr_wr = 0, i, l0;
	int          n_done = 0, d0;

	always #20 pclk = ~pclk;

	esm_timing_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_address_strobe(cpu_address_strobe), .mem_select_n(mem_select_n), .cpu_read(cpu_read),
		.transfer_acknowledge_n(transfer_acknowledge_n), .cpu_bus_fault_n(cpu_bus_fault_n),
		.cpu_halt_n(cpu_halt_n), .ras_request_n(ras_request_n), .addr_latch_en(addr_latch_en),
		.refresh_mode(refresh_mode), .refresh_done_n(refresh_done_n), .access_err_n(access_err_n),
		.acc_dir(acc_dir), .acc_oe_n(acc_oe_n), .acc_latch_en(acc_latch_en),
		.correct_mode_select(correct_mode_select), .scr_dir(scr_dir), .scr_oe_n(scr_oe_n));

	esm_far_model u_far (.pclk(pclk), .presetn(presetn), .inject(inject), .any_dir(any_dir),
		.refresh_mode(refresh_mode), .acc_dir(acc_dir), .scr_dir(scr_dir), .access_err_n(access_err_n));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			print_verdict();
		end
		@(posedge pclk);
	endtask

	// Processor access; strobe held until five cycles after acknowledge, fault watched in those five cycles
	task automatic cpu(input logic rdn, input logic io);
		int n;
		cpu_address_strobe <= 1'b1;
		cpu_read <= rdn;
		mem_select_n <= io;
		ack = 0;
		flt = 0;
		cms = 0;
		lat = 0;
		wdir = 0;
		ale = 0;
		for (n = 0; n < 60 && !ack; n++) begin
			@(posedge pclk);
			ack = (transfer_acknowledge_n === 1'b0);
			lat |= (addr_latch_en === 1'b0);
			wdir |= (acc_dir === 1'b0);
		end
		repeat (5) begin
			@(posedge pclk);
			flt |= (cpu_bus_fault_n === 1'b0 && cpu_halt_n === 1'b0);
			cms |= (correct_mode_select === 1'b1);
			lat |= (addr_latch_en === 1'b0);
			wdir |= (acc_dir === 1'b0);
			ale |= (acc_latch_en === 1'b1);
		end
		cpu_address_strobe <= 1'b0;
		mem_select_n <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask

	task automatic wait_ref(input logic lvl);
		for (i = 0; i < 500 && refresh_mode !== lvl; i++)
			@(posedge pclk);
		if (i >= 500) begin
			err_count++;
			print_verdict();
		end
	endtask

	always @(posedge pclk) begin
		if (refresh_mode === 1'b1) begin
			ref_cyc++;
			if (scr_dir === 1'b0)
				scr_wr++;
			if (refresh_done_n === 1'b0)
				n_done++;
			chk({30'h0, acc_oe_n, transfer_acknowledge_n}, 32'h3);
		end else if (ref_cyc != 0) begin
			ref_len = ref_cyc;
			ref_cyc = 0;
		end
	end

	initial begin
		rows = '{{8'h00, 32'h1, 1'b0}, {8'h08, 32'h0, 1'b0}, {8'h0c, 32'h0, 1'b0},
			{8'h10, 32'h0, 1'b1}, {8'hfc, 32'h0, 1'b1}};
		repeat (5) @(posedge pclk);
		chk({ras_request_n, transfer_acknowledge_n, cpu_bus_fault_n, refresh_mode, correct_mode_select}, 32'h1c);
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		for (int r = 0; r < 5; r++) begin
			apb(1'b0, rows[r][40:33], 32'h0);
			chk({rd[30:0], er}, {rows[r][31:1], rows[r][0]});
		end
		$display("test registers done");
		cpu(1'b0, 1'b0);
		chk({ack, flt}, 32'h2);
		chk({wdir, lat, ale}, 32'h4);
		cpu(1'b1, 1'b0);
		chk({ack, flt}, 32'h2);
		chk({wdir, lat, ale}, 32'h1);
		cpu(1'b1, 1'b1);
		chk(ack, 1'b0);
		$display("test plain access done");
		wait_ref(1'b1);
		chk({scr_oe_n, scr_dir}, 32'h1);
		inject <= 1'b1;
		l0 = scr_wr;
		wait_ref(1'b0);
		inject <= 1'b0;
		chk(scr_wr - l0, 2);
		apb(1'b0, ESM_SCRUB_OFS, 32'h0);
		chk(rd[15:0], 16'h1);
		wait_ref(1'b1);
		wait_ref(1'b0);
		chk(scr_wr - l0, 2);
		apb(1'b1, ESM_CTRL_OFS, 32'h0);
		l0 = ref_len;
		d0 = n_done;
		wait_ref(1'b1);
		chk({scr_oe_n, scr_dir}, 32'h3);
		wait_ref(1'b0);
		@(posedge pclk);
		chk(l0 - ref_len, 3);
		chk(n_done - d0, 1);
		$display("test scrub done");
		apb(1'b1, ESM_CTRL_OFS, 32'h2);
		cpu(1'b1, 1'b0);
		chk({ack, flt, cms}, 32'h4);
		inject <= 1'b1;
		cpu(1'b1, 1'b0);
		inject <= 1'b0;
		chk({flt, cms}, 32'h3);
		chk({wdir, lat, ale}, 32'h7);
		cpu(1'b1, 1'b0);
		chk({ack, flt}, 32'h2);
		apb(1'b0, ESM_FIX_OFS, 32'h0);
		chk(rd[15:0], 16'h1);
		inject <= 1'b1;
		any_dir <= 1'b1;
		cpu(1'b0, 1'b0);
		inject <= 1'b0;
		any_dir <= 1'b0;
		chk(flt, 1'b0);
		chk({wdir, lat, ale}, 32'h4);
		$display("test correct on error done");
		wait_ref(1'b1);
		cpu(1'b1, 1'b0);
		chk({ack, flt}, 32'h2);
		$display("test access during refresh done");
		print_verdict();
	end
endmodule
